/* logic/sfd_decoder.sv */
/*
 * Vector instruction format decoder: classifies a fetched 32-bit word,
 * extracts its fields and flags reserved encodings, one registered stage.
 * Assumes the fetch stage drives instr_word and instr_valid on core_clk.
 */
`timescale 1ns/1ns
`default_nettype none

`include "sfd_params.svh"

module sfd_decoder
   import sfd_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   input  wire logic        instr_valid,
   input  wire logic [31:0] instr_word,
   output sfd_decode_t      dec_out
);

   // ==========================================================================
   // Helpers
   function automatic sfd_size_t df2_size(input logic [1:0] code);
      unique case (code)
         2'h0: df2_size = SZ_BYTE;
         2'h1: df2_size = SZ_HALF;
         2'h2: df2_size = SZ_WORD;
         2'h3: df2_size = SZ_DOUBLE;
      endcase
   endfunction

   // Single-bit format for the float forms: word or doubleword
   function automatic sfd_size_t df1_size(input logic code);
      df1_size = code ? SZ_DOUBLE : SZ_WORD;
   endfunction

   function automatic sfd_fmt_t classify_minor(input logic [5:0] minor,
                                               input logic [2:0] op3,
                                               input logic [4:0] op5);
      classify_minor = FMT_NONE;
      if (minor <= `SFD_MIN_IMM8_HI) begin
         classify_minor = FMT_IMM_EIGHT;
      end else if (minor == `SFD_MIN_IMM5_A) begin
         classify_minor = FMT_IMM_FIVE;
      end else if (minor == `SFD_MIN_IMM5_B) begin
         classify_minor = (op3 == `SFD_IMM10_OP) ? FMT_IMM_TEN : FMT_IMM_FIVE;
      end else if (minor == `SFD_MIN_BIT_A || minor == `SFD_MIN_BIT_B) begin
         classify_minor = FMT_BIT_INDEX;
      end else if (minor >= `SFD_MIN_TREG_LO && minor <= `SFD_MIN_TREG_HI) begin
         classify_minor = FMT_THREE_REG;
      end else if (minor == `SFD_MIN_ELEM) begin
         classify_minor = FMT_ELEMENT;
      end else if (minor >= `SFD_MIN_TREGF_LO && minor <= `SFD_MIN_TREGF_HI) begin
         classify_minor = FMT_THREE_REG_FLOAT;
      end else if (minor == `SFD_MIN_WVEC) begin
         if (op5 == `SFD_WVEC_TWOREG_SEL) begin
            classify_minor = FMT_TWO_REG;
         end else if (op5 == `SFD_WVEC_TWOREGF_SEL) begin
            classify_minor = FMT_TWO_REG_FLOAT;
         end else begin
            classify_minor = FMT_WHOLE_VECTOR;
         end
      end else if (minor[5:3] == `SFD_MIN_LDST_ROW) begin
         classify_minor = FMT_LOAD_STORE;
      end
   endfunction

   // ==========================================================================
   // Field views of the incoming word
   sfd_state_t  st;
   sfd_state_t  next_st;
   sfd_index_t  elem_info;
   sfd_index_t  bit_info;
   logic [5:0]  major;
   logic [4:0]  branch_sel;
   logic        is_branch;

   assign major      = instr_word[`SFD_MAJOR_HI:`SFD_MAJOR_LO];
   assign branch_sel = instr_word[`SFD_OP_HI:21];
   assign is_branch  = (major == `SFD_MAJOR_COPROC_ONE) &&
                       (branch_sel == `SFD_BR_ALL_ZERO || branch_sel == `SFD_BR_ANY_NONZERO ||
                        branch_sel[4:3] == `SFD_BR_SIZED_PREFIX); // see [RQ7]

   sfd_index_decode u_elem_decode (
      .field    ({1'b0, instr_word[21:16]}),
      .bit_mode (1'b0),
      .info     (elem_info)
   );

   sfd_index_decode u_bit_decode (
      .field    (instr_word[22:16]),
      .bit_mode (1'b1),
      .info     (bit_info)
   );

   // ==========================================================================
   // Next-state decode
   always_comb begin
      next_st                   = st;
      next_st.dec               = '0;
      next_st.dec.fmt           = FMT_NONE;
      next_st.dec.elem_size     = SZ_NONE;
      next_st.dec.op            = `SFD_RESET_OP;
      next_st.dec.valid         = instr_valid;
      next_st.dec.minor         = instr_word[5:0];
      next_st.dec.tgt_vreg      = instr_word[20:`SFD_TGT_LO];
      next_st.dec.src_vreg      = instr_word[15:`SFD_SRC_LO];
      next_st.dec.dest_vreg     = instr_word[10:`SFD_DST_LO];
      if (major == `SFD_MAJOR_SIMD) begin
         next_st.dec.is_simd = 1'b1;
         next_st.dec.fmt     = classify_minor(instr_word[5:0], instr_word[25:23],
                                              instr_word[25:21]); // see [RQ6]
         unique case (next_st.dec.fmt)
            FMT_IMM_EIGHT: begin
               // Selector is the format for some ops and an operation bit for others
               next_st.dec.op        = {7'h00, instr_word[25:24]}; // see [RQ8]
               next_st.dec.elem_size = SZ_BYTE;
               next_st.dec.imm_eight = instr_word[23:16]; // see [RQ8]
            end
            FMT_IMM_FIVE: begin
               next_st.dec.op        = {6'h00, instr_word[25:23]}; // see [RQ9]
               next_st.dec.elem_size = df2_size(instr_word[22:21]); // see [RQ9] [RQ1]
               next_st.dec.imm_five  = instr_word[20:16]; // see [RQ9]
            end
            FMT_BIT_INDEX: begin
               next_st.dec.op         = {6'h00, instr_word[25:23]}; // see [RQ10]
               next_st.dec.elem_size  = bit_info.size; // see [RQ10]
               next_st.dec.elem_index = bit_info.index;
               next_st.dec.reserved   = bit_info.bad; // see [RQ3]
            end
            FMT_IMM_TEN: begin
               next_st.dec.op        = {6'h00, instr_word[25:23]}; // see [RQ11]
               next_st.dec.elem_size = df2_size(instr_word[22:21]); // see [RQ11]
               next_st.dec.imm_ten   = instr_word[20:11]; // see [RQ11]
            end
            FMT_THREE_REG: begin
               next_st.dec.op        = {6'h00, instr_word[25:23]}; // see [RQ12]
               next_st.dec.elem_size = df2_size(instr_word[22:21]); // see [RQ12]
            end
            FMT_ELEMENT: begin
               next_st.dec.op         = {5'h00, instr_word[25:22]}; // see [RQ13]
               next_st.dec.elem_size  = elem_info.size; // see [RQ13]
               next_st.dec.elem_index = elem_info.index;
               next_st.dec.reserved   = elem_info.bad; // see [RQ3]
            end
            FMT_THREE_REG_FLOAT: begin
               next_st.dec.op        = {5'h00, instr_word[25:22]}; // see [RQ14]
               next_st.dec.elem_size = df1_size(instr_word[21]); // see [RQ14]
            end
            FMT_WHOLE_VECTOR: begin
               next_st.dec.op        = {4'h0, instr_word[25:21]}; // see [RQ15]
               next_st.dec.elem_size = SZ_VECTOR; // see [RQ15] [RQ20]
               next_st.dec.reserved  = instr_word[25:21] > `SFD_WVEC_OP_MAX; // see [RQ21]
            end
            FMT_LOAD_STORE: begin
               next_st.dec.op              = {4'h0, instr_word[25], instr_word[5:2]}; // see [RQ16]
               next_st.dec.elem_size       = df2_size(instr_word[1:0]); // see [RQ16]
               next_st.dec.signed_offset10 = instr_word[25:16]; // see [RQ16]
               next_st.dec.base_gpr        = instr_word[15:11]; // see [RQ16]
               next_st.dec.src_vreg        = 5'h00;
            end
            FMT_TWO_REG: begin
               next_st.dec.op        = {1'b0, instr_word[25:18]}; // see [RQ17]
               next_st.dec.elem_size = df2_size(instr_word[17:16]); // see [RQ17]
            end
            FMT_TWO_REG_FLOAT: begin
               next_st.dec.op        = instr_word[25:17]; // see [RQ18]
               next_st.dec.elem_size = df1_size(instr_word[16]); // see [RQ18]
            end
            default: begin
               // Unallocated minor opcode inside the vector major opcode
               next_st.dec.reserved = 1'b1; // see [RQ21] [RQ3]
            end
         endcase
      end else if (is_branch) begin
         next_st.dec.is_simd       = 1'b1;
         next_st.dec.fmt           = FMT_BRANCH;
         next_st.dec.op            = {6'h00, instr_word[25:23]}; // see [RQ19]
         next_st.dec.elem_size     = (branch_sel[4:3] == `SFD_BR_SIZED_PREFIX) ?
                                     df2_size(instr_word[22:21]) : SZ_VECTOR; // see [RQ19]
         next_st.dec.branch_disp16 = instr_word[15:0]; // see [RQ19]
         next_st.dec.src_vreg      = 5'h00;
         next_st.dec.dest_vreg     = 5'h00;
      end
   end

   // ==========================================================================
   // State register; one stage so the whole record changes on one edge
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st; // see [RQ23]
      end
   end

   assign dec_out = st.dec;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_take(logic cond);
      clk_en && instr_valid && cond;
   endsequence

   sequence s_shows(logic cond);
      dec_out.valid && cond;
   endsequence

   simd_major_a: assert property ( // see [RQ6]
      s_take(major == `SFD_MAJOR_SIMD) |=> s_shows(dec_out.is_simd && dec_out.fmt != FMT_BRANCH))
      else $error("vector major opcode not recognised");

   branch_df_a: assert property ( // see [RQ7]
      s_take(major == `SFD_MAJOR_COPROC_ONE && branch_sel[4:3] == `SFD_BR_SIZED_PREFIX) |=>
      s_shows(dec_out.fmt == FMT_BRANCH &&
              dec_out.elem_size == df2_size($past(instr_word[22:21]))))
      else $error("branch data format wrong");

   byte_index_a: assert property ( // see [RQ4]
      s_take(major == `SFD_MAJOR_SIMD && instr_word[5:0] == `SFD_MIN_ELEM &&
             instr_word[21:20] == 2'h1) |=> s_shows(dec_out.reserved))
      else $error("byte index above fifteen accepted");

   half_index_a: assert property ( // see [RQ22]
      s_take(major == `SFD_MAJOR_SIMD && instr_word[5:0] == `SFD_MIN_ELEM &&
             instr_word[21:20] == 2'h2) |=>
      s_shows(dec_out.elem_size == SZ_HALF &&
              dec_out.reserved == $past(instr_word[19])))
      else $error("halfword index check wrong");

   word_index_a: assert property ( // see [RQ2]
      s_take(major == `SFD_MAJOR_SIMD && instr_word[5:0] == `SFD_MIN_ELEM &&
             instr_word[21:19] == 3'h6 && !instr_word[18]) |=>
      s_shows(dec_out.elem_size == SZ_WORD && !dec_out.reserved &&
              dec_out.elem_index == {4'h0, $past(instr_word[17:16])}))
      else $error("word element index wrong");

   bit_dword_a: assert property ( // see [RQ5]
      s_take(major == `SFD_MAJOR_SIMD && instr_word[5:0] == `SFD_MIN_BIT_A &&
             !instr_word[22]) |=>
      s_shows(dec_out.elem_size == SZ_DOUBLE &&
              dec_out.elem_index == $past(instr_word[21:16])))
      else $error("doubleword bit index wrong");

   imm8_fields_a: assert property ( // see [RQ8]
      s_take(major == `SFD_MAJOR_SIMD && instr_word[5:0] <= `SFD_MIN_IMM8_HI) |=>
      s_shows(dec_out.imm_eight == $past(instr_word[23:16]) &&
              dec_out.dest_vreg == $past(instr_word[10:6]) &&
              dec_out.src_vreg == $past(instr_word[15:11])))
      else $error("eight-bit immediate fields wrong");

   load_store_a: assert property ( // see [RQ16]
      s_take(major == `SFD_MAJOR_SIMD && instr_word[5:3] == 3'h4) |=>
      s_shows(dec_out.fmt == FMT_LOAD_STORE &&
              dec_out.signed_offset10 == $past(instr_word[25:16]) &&
              dec_out.base_gpr == $past(instr_word[15:11])))
      else $error("load/store fields wrong");

   unalloc_minor_a: assert property ( // see [RQ21]
      s_take(major == `SFD_MAJOR_SIMD && instr_word[5:0] == 6'h03) |=>
      s_shows(dec_out.reserved && dec_out.fmt == FMT_NONE))
      else $error("unallocated minor opcode not reserved");

   wvec_implied_a: assert property ( // see [RQ20]
      s_take(major == `SFD_MAJOR_SIMD && instr_word[5:0] == `SFD_MIN_WVEC &&
             instr_word[25:21] <= `SFD_WVEC_OP_MAX) |=>
      s_shows(dec_out.elem_size == SZ_VECTOR && !dec_out.reserved))
      else $error("whole-vector op decoded with element size");

   foreign_word_a: assert property ( // see [RQ23]
      s_take(major != `SFD_MAJOR_SIMD && major != `SFD_MAJOR_COPROC_ONE) |=>
      s_shows(!dec_out.is_simd && !dec_out.reserved))
      else $error("foreign instruction marked as vector");

   freeze_a: assert property ( // see [RQ23]
      !clk_en |=> $stable(dec_out))
      else $error("decode changed while clock enable low");

   idle_slot_a: assert property ( // see [RQ23]
      clk_en && !instr_valid |=> !dec_out.valid ##1
      (dec_out.valid == ($past(clk_en) && $past(instr_valid)) || !$past(clk_en)))
      else $error("valid raised for an empty slot");

endmodule // sfd_decoder

`default_nettype wire

/* common/sfd_params.svh */
/*
 * Constants of the vector instruction format decoder: opcode values,
 * field positions, minor opcode allocation and reset values.
 * Assumes it is included by bare name after the package that holds the types.
 */
// Contract
// [RQ1] Ordinary vector instructions carry element size in a two-bit format code.
// [RQ2] Element field: 00 byte with 4-bit index, 10 halfword, 110 word with 2-bit index.
// [RQ3] Invalid data-format code or element index raises Reserved Instruction.
// [RQ4] Byte element index above fifteen is invalid and raises Reserved Instruction.
// [RQ5] Bit field: leading ones pick size; leading zero gives doubleword, 6-bit index.
// [RQ6] Non-branch vector instructions use major opcode 30, told apart by minor opcode.
// [RQ7] Vector branches use major opcode 17 with ten allocated five-bit selector values.
// [RQ8] 8-bit immediate form: selector 25..24, immediate, two registers, minor opcode.
// [RQ9] 5-bit immediate form: operation 25..23, format 22..21, immediate, two registers.
// [RQ10] Bit-index form: operation 25..23, format and bit index 22..16, two registers.
// [RQ11] 10-bit immediate form: operation 25..23, format 22..21, immediate, destination.
// [RQ12] Three-register form: operation 25..23, format 22..21, three 5-bit registers.
// [RQ13] Element form: 4-bit operation 25..22, format and index 21..16, two registers.
// [RQ14] Three-register float form: operation 25..22, bit 21 picks word or doubleword.
// [RQ15] Whole-vector form: 5-bit operation 25..21, size implied by the operation.
// [RQ16] Load/store: signed offset, base register, destination; op 25 and 5..2; format 1..0.
// [RQ17] Two-register form: 8-bit operation 25..18, format 17..16, two registers.
// [RQ18] Two-register float form: 9-bit operation 25..17, bit 16 picks element size.
// [RQ19] Branch: operation 25..23, format 22..21, tested register, 16-bit displacement.
// [RQ20] Whole-vector format combinations denote instructions without element sizes.
// [RQ21] Reserved operation or field codes raise Reserved Instruction.
// [RQ22] Halfword index 0..7, word 0..3, doubleword 0..1; larger values are invalid.
// [RQ23] Fields, format class and reserved flag appear together for each instruction.
`ifndef SFD_PARAMS_SVH
`define SFD_PARAMS_SVH

// ==========================================================================
// Major opcodes and branch selector values
`define SFD_MAJOR_SIMD        6'h1E
`define SFD_MAJOR_COPROC_ONE  6'h11
`define SFD_BR_ALL_ZERO       5'h0B
`define SFD_BR_ANY_NONZERO    5'h0F
`define SFD_BR_SIZED_PREFIX   2'h3

// ==========================================================================
// Minor opcode allocation
`define SFD_MIN_IMM8_HI       6'h02
`define SFD_MIN_IMM5_A        6'h06
`define SFD_MIN_IMM5_B        6'h07
`define SFD_MIN_BIT_A         6'h09
`define SFD_MIN_BIT_B         6'h0A
`define SFD_MIN_TREG_LO       6'h0D
`define SFD_MIN_TREG_HI       6'h15
`define SFD_MIN_ELEM          6'h19
`define SFD_MIN_TREGF_LO      6'h1A
`define SFD_MIN_TREGF_HI      6'h1C
`define SFD_MIN_WVEC          6'h1E
`define SFD_MIN_LDST_ROW      3'h4
`define SFD_IMM10_OP          3'h6
`define SFD_WVEC_TWOREG_SEL   5'h18
`define SFD_WVEC_TWOREGF_SEL  5'h19
`define SFD_WVEC_OP_MAX       5'h06

// ==========================================================================
// Field positions
`define SFD_MAJOR_HI        31
`define SFD_MAJOR_LO        26
`define SFD_OP_HI           25
`define SFD_TGT_LO          16
`define SFD_SRC_LO          11
`define SFD_DST_LO          6

// ==========================================================================
// Reset values
`define SFD_RESET_OP        9'h000

`endif

/* common/sfd_pkg.sv */
/*
 * Types shared by the decoder files: format classes, element sizes,
 * index decode result and the decoded instruction record.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package sfd_pkg;

   // ==========================================================================
   // Enumerations
   typedef enum logic [3:0] {
      FMT_NONE, FMT_IMM_EIGHT, FMT_IMM_FIVE, FMT_BIT_INDEX, FMT_IMM_TEN,
      FMT_THREE_REG, FMT_ELEMENT, FMT_THREE_REG_FLOAT, FMT_WHOLE_VECTOR,
      FMT_LOAD_STORE, FMT_TWO_REG, FMT_TWO_REG_FLOAT, FMT_BRANCH
   } sfd_fmt_t;

   typedef enum logic [2:0] {
      SZ_NONE, SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DOUBLE, SZ_VECTOR
   } sfd_size_t;

   // ==========================================================================
   // Records
   typedef struct packed {
      sfd_size_t  size;
      logic [5:0] index;
      logic       bad;
   } sfd_index_t;

   typedef struct packed {
      logic        valid;
      logic        is_simd;
      logic        reserved;
      sfd_fmt_t    fmt;
      sfd_size_t   elem_size;
      logic [8:0]  op;
      logic [5:0]  minor;
      logic [5:0]  elem_index;
      logic [4:0]  tgt_vreg;
      logic [4:0]  src_vreg;
      logic [4:0]  dest_vreg;
      logic [4:0]  base_gpr;
      logic [7:0]  imm_eight;
      logic [4:0]  imm_five;
      logic [9:0]  imm_ten;
      logic [9:0]  signed_offset10;
      logic [15:0] branch_disp16;
   } sfd_decode_t;

   typedef struct packed {
      sfd_decode_t dec;
   } sfd_state_t;

endpackage

`default_nettype wire

/* logic/sfd_index_decode.sv */
/*
 * Combined format/index field decoder, element form or bit-position form.
 * Assumes the field is taken from an instruction word on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module sfd_index_decode
   import sfd_pkg::*;
(
   input  wire logic [6:0] field,
   input  wire logic       bit_mode,
   output sfd_index_t      info
);

   always_comb begin
      info = '{size: SZ_VECTOR, index: 6'h00, bad: 1'b0};
      if (bit_mode) begin
         unique casez (field)
            7'b0??????: info = '{size: SZ_DOUBLE, index: field[5:0], bad: 1'b0}; // see [RQ5]
            7'b10?????: info = '{size: SZ_WORD, index: {1'b0, field[4:0]}, bad: 1'b0}; // see [RQ5]
            7'b110????: info = '{size: SZ_HALF, index: {2'h0, field[3:0]}, bad: 1'b0}; // see [RQ5]
            7'b1110???: info = '{size: SZ_BYTE, index: {3'h0, field[2:0]}, bad: 1'b0}; // see [RQ5]
            default:    info = '{size: SZ_NONE, index: 6'h00, bad: 1'b1}; // see [RQ3]
         endcase
      end else begin
         // Index fields are one bit wider than the valid range; the top bit flags misuse
         unique casez (field[5:0])
            6'b0?????: info = '{size: SZ_BYTE, index: {1'b0, field[4:0]}, bad: field[4]}; // see [RQ2] [RQ4]
            6'b10????: info = '{size: SZ_HALF, index: {2'h0, field[3:0]}, bad: field[3]}; // see [RQ2] [RQ22]
            6'b110???: info = '{size: SZ_WORD, index: {3'h0, field[2:0]}, bad: field[2]}; // see [RQ2] [RQ22]
            6'b1110??: info = '{size: SZ_DOUBLE, index: {4'h0, field[1:0]}, bad: field[1]}; // see [RQ22]
            6'b111110: info = '{size: SZ_VECTOR, index: 6'h00, bad: 1'b0}; // see [RQ20]
            default:   info = '{size: SZ_NONE, index: 6'h00, bad: 1'b1}; // see [RQ3]
         endcase
      end
   end

endmodule // sfd_index_decode

`default_nettype wire

/* bench/sfd_fetch_model.sv */
/*
 * Fetch stage model: presents one instruction word per request to the decoder.
 * Assumes the bench raises send for one core_clk cycle per word it hands over.
 */
`timescale 1ns/1ns
`default_nettype none

module sfd_fetch_model (
   input  wire logic        core_clk,
   input  wire logic        send,
   input  wire logic [31:0] send_word,
   output var  logic        instr_valid,
   output var  logic [31:0] instr_word
);
   // ==========================================================================
   // Presentation
   initial begin
      instr_valid = 1'b0;
      instr_word  = 32'h0000_0000;
   end

   // Idle word flips each cycle so a stale word never looks like a held one
   always @(posedge core_clk) begin
      instr_valid <= send;
      instr_word  <= send ? send_word : ~instr_word;
   end
endmodule // sfd_fetch_model

`default_nettype wire

/* bench/tb_sfd_decoder.sv */
/*
 * Self-checking bench of the vector instruction decoder, one task per scenario.
 * Assumes the fetch model delivers each word one edge after it is requested.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) begin \
   total_checks++; \
   if ((got) !== (ex)) begin \
      bad_count++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
   end \
end

module tb_sfd_decoder
   import sfd_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        clk_en = 1'b1;
   logic        send = 1'b0;
   logic [31:0] send_word = 32'h0000_0000;
   logic        instr_valid;
   logic [31:0] instr_word;
   sfd_decode_t dec;
   int          bad_count = 0;
   int          total_checks = 0;

   sfd_fetch_model u_sfd_fetch_model (
      .core_clk    (core_clk),
      .send        (send),
      .send_word   (send_word),
      .instr_valid (instr_valid),
      .instr_word  (instr_word)
   );

   sfd_decoder u_sfd_decoder (
      .core_clk    (core_clk),
      .nrst        (nrst),
      .clk_en      (clk_en),
      .instr_valid (instr_valid),
      .instr_word  (instr_word),
      .dec_out     (dec)
   );

   always #20 core_clk = ~core_clk;

   // ==========================================================================
   // Shared steps
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Record of the word appears two edges after the bench requests it
   task automatic put(input logic [31:0] w);
      @(posedge core_clk);
      send      <= 1'b1;
      send_word <= w;
      @(posedge core_clk);
      send <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask

   task automatic hdr(input sfd_fmt_t f, input sfd_size_t s, input logic r);
      `CHK("valid", 1'b1, dec.valid)
      `CHK("is_simd", (f != FMT_NONE) || r, dec.is_simd)
      `CHK("fmt", f, dec.fmt)
      `CHK("reserved", r, dec.reserved)
      if (!r) `CHK("elem_size", s, dec.elem_size)
   endtask

   // ==========================================================================
   // Scenarios
   task automatic t_register_forms();
      sfd_size_t sz[4] = '{SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DOUBLE};
      put({6'h1E, 3'h3, 2'h2, 5'h05, 5'h09, 5'h11, 6'h0D});
      hdr(FMT_THREE_REG, SZ_WORD, 1'b0);
      `CHK("three reg", {9'h003, 15'h1531}, {dec.op, dec.tgt_vreg, dec.src_vreg, dec.dest_vreg})
      for (int i = 0; i < 4; i++) begin
         put({6'h1E, 3'h2, 2'(i), 5'h1B, 5'h04, 5'h08, 6'h06});
         hdr(FMT_IMM_FIVE, sz[i], 1'b0);
         `CHK("imm five", {9'h002, 15'h6C88}, {dec.op, dec.imm_five, dec.src_vreg, dec.dest_vreg})
      end
   endtask

   task automatic t_immediates();
      put({6'h1E, 2'h1, 8'hA5, 5'h03, 5'h1F, 6'h01});
      hdr(FMT_IMM_EIGHT, SZ_BYTE, 1'b0);
      `CHK("imm eight", {9'h001, 8'hA5}, {dec.op, dec.imm_eight})
      `CHK("imm eight regs", 10'h07F, {dec.src_vreg, dec.dest_vreg})
      put({6'h1E, 3'h6, 2'h1, 10'h2C3, 5'h0E, 6'h07});
      hdr(FMT_IMM_TEN, SZ_HALF, 1'b0);
      `CHK("imm ten", {10'h2C3, 5'h0E}, {dec.imm_ten, dec.dest_vreg})
   endtask

   task automatic t_float_vector();
      for (int b = 0; b < 2; b++) begin
         put({6'h1E, 4'h9, 1'(b), 15'h0864, 6'h1B});
         hdr(FMT_THREE_REG_FLOAT, b ? SZ_DOUBLE : SZ_WORD, 1'b0);
         `CHK("float three op", 9'h009, dec.op)
         put({6'h1E, 9'h190, 1'(b), 10'h0A6, 6'h1E});
         hdr(FMT_TWO_REG_FLOAT, b ? SZ_DOUBLE : SZ_WORD, 1'b0);
         `CHK("float two op", 9'h190, dec.op)
      end
      put({6'h1E, 5'h01, 15'h0864, 6'h1E});
      hdr(FMT_WHOLE_VECTOR, SZ_VECTOR, 1'b0);
      `CHK("whole op", 9'h001, dec.op)
      put({6'h1E, 5'h07, 15'h0864, 6'h1E});
      hdr(FMT_WHOLE_VECTOR, SZ_VECTOR, 1'b1);
      put({6'h1E, 8'hC1, 2'h3, 10'h0A6, 6'h1E});
      hdr(FMT_TWO_REG, SZ_DOUBLE, 1'b0);
      `CHK("two reg op", 9'h0C1, dec.op)
   endtask

   task automatic t_load_store();
      put({6'h1E, 10'h3F8, 5'h0A, 5'h15, 4'h8, 2'h2});
      hdr(FMT_LOAD_STORE, SZ_WORD, 1'b0);
      `CHK("offset op", {10'h3F8, 9'h018}, {dec.signed_offset10, dec.op})
      `CHK("ldst regs", 15'h2815, {dec.base_gpr, dec.src_vreg, dec.dest_vreg})
      `CHK("minor", 6'h22, dec.minor)
   endtask

   // Odd entries of f step one past the largest legal index; in g only the last entry does
   task automatic t_index_fields();
      logic [5:0] f[8] = '{6'h0F, 6'h10, 6'h27, 6'h28, 6'h33, 6'h34, 6'h39, 6'h3A};
      logic [6:0] g[5] = '{7'h3F, 7'h5F, 7'h6F, 7'h77, 7'h78};
      logic [5:0] ix[4] = '{6'h0F, 6'h07, 6'h03, 6'h01};
      logic [5:0] bx[4] = '{6'h3F, 6'h1F, 6'h0F, 6'h07};
      sfd_size_t  s[4] = '{SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DOUBLE};
      for (int i = 0; i < 8; i++) begin
         put({6'h1E, 4'h5, f[i], 10'h0E8, 6'h19});
         hdr(FMT_ELEMENT, s[i/2], 1'(i % 2));
         if (i % 2 == 0) `CHK("elem", {ix[i/2], 9'h005}, {dec.elem_index, dec.op})
      end
      for (int i = 0; i < 5; i++) begin
         put({6'h1E, 3'h1, g[i], 10'h0E8, 6'h09});
         hdr(FMT_BIT_INDEX, s[3 - i % 4], i == 4);
         if (i < 4) `CHK("bit idx", bx[i], dec.elem_index)
      end
   endtask

   task automatic t_branch_foreign();
      put({6'h11, 5'h1A, 5'h0C, 16'hBEEF});
      hdr(FMT_BRANCH, SZ_WORD, 1'b0);
      `CHK("branch", {9'h006, 5'h0C, 16'hBEEF}, {dec.op, dec.tgt_vreg, dec.branch_disp16})
      put({6'h11, 5'h0B, 21'h00_0000});
      hdr(FMT_BRANCH, SZ_VECTOR, 1'b0);
      put({6'h11, 5'h00, 21'h00_0000});
      hdr(FMT_NONE, SZ_NONE, 1'b0);
      put({6'h00, 26'h3FF_FFFF});
      hdr(FMT_NONE, SZ_NONE, 1'b0);
      put({6'h1E, 20'h0_0000, 6'h03});
      hdr(FMT_NONE, SZ_NONE, 1'b1);
      put({6'h1E, 20'h0_0000, 6'h3F});
      hdr(FMT_NONE, SZ_NONE, 1'b1);
   endtask

   // Back to back words, then a frozen clock enable must hold the last record
   task automatic t_stream_hold();
      @(posedge core_clk);
      send      <= 1'b1;
      send_word <= {6'h1E, 3'h3, 2'h2, 15'h0864, 6'h0D};
      @(posedge core_clk);
      send_word <= {6'h1E, 5'h02, 15'h0864, 6'h1E};
      @(posedge core_clk);
      send <= 1'b0;
      #1;
      hdr(FMT_THREE_REG, SZ_WORD, 1'b0);
      @(posedge core_clk);
      clk_en <= 1'b0;
      #1;
      hdr(FMT_WHOLE_VECTOR, SZ_VECTOR, 1'b0);
      repeat (3) @(posedge core_clk);
      #1;
      hdr(FMT_WHOLE_VECTOR, SZ_VECTOR, 1'b0);
      @(posedge core_clk);
      clk_en <= 1'b1;
      // The first enabled edge takes an empty slot, so valid must drop
      @(posedge core_clk);
      #1;
      `CHK("idle valid", 1'b0, dec.valid)
   endtask

   // ==========================================================================
   // Sequence and watchdog
   initial begin
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      `CHK("reset record", '0, dec)
      t_register_forms();
      t_immediates();
      t_float_vector();
      t_load_store();
      t_index_fields();
      t_branch_foreign();
      t_stream_hold();
      close_out();
   end

   // About 127 cycles of traffic are expected; the margin covers a stuck run
   initial begin
      #(4000 * 40);
      bad_count++;
      close_out();
   end
endmodule // tb_sfd_decoder

`default_nettype wire
